//--- common/fpe_pkg.sv
// Package of constants and types shared by the flash sequencer and its host.
// Overview of operation
// - Control register: bits 7..4 zero, four control bits
// - High voltage needs write or wipe step done
// - High voltage drives pump and array voltage
// - Wipe with whole-array bit erases everything
// - Write and wipe selects are mutually exclusive
// - Erase page is 128 aligned bytes, first latch
// - Vector page cleared only by whole-array erase
// - Host page erase step order and waits
// - Host whole-array erase step order and waits
// - Host waits recovery before reading array
// - Program rows are 64 aligned bytes
// - Write select enables address and data latching
// - Host writes each byte then waits
// - Host runs flash routines from RAM only
// - Steps in order, unrelated bus traffic tolerated
// - Protected address refuses high-voltage enable
// - Protect start from boundary bits 7..1
// - Boundary all ones disables protection
// - Protection runs through address ffff
// - Zero boundary protects from c000 upward
// - Erased reads one, programming only clears
// - User array 12288 bytes plus vector block
`default_nettype none
package fpe_pkg;
    localparam logic [15:0] CTRL_ADDR = 16'hfe08;
    localparam logic [15:0] PROT_ADDR = 16'hfe09;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] PROT_RESET = 8'h00;
    localparam logic [7:0] PROT_OFF = 8'hff;
    localparam int BIT_HV = 3;
    localparam int BIT_MASS = 2;
    localparam int BIT_WIPE = 1;
    localparam int BIT_WRITE = 0;
    localparam logic [15:0] USER_BASE = 16'hc000;
    localparam logic [15:0] USER_LAST = 16'hefff;
    localparam logic [15:0] VEC_BASE = 16'hffd0;
    localparam logic [15:0] VEC_LAST = 16'hffff;
    localparam int USER_BYTES = 12288;
    localparam int VEC_BYTES = 48;
    localparam int PAGE_BITS = 7;
    localparam int ROW_BITS = 6;
    // Host wait times in ns, and cycle counts at the 25 MHz clock
    localparam int CLK_NS = 40;
    localparam int T_NVS_NS = 10000;
    localparam int T_ERASE_NS = 1000000;
    localparam int T_MERASE_NS = 4000000;
    localparam int T_NVH_NS = 5000;
    localparam int T_NVHL_NS = 100000;
    localparam int PROGRAM_SETUP_WAIT_NS = 5000;
    localparam int T_PROG_NS = 30000;
    localparam int T_RCV_NS = 1000;
    localparam int NVS_CYC = (T_NVS_NS + CLK_NS - 1) / CLK_NS;
    localparam int ERASE_CYC = (T_ERASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int MERASE_CYC = (T_MERASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int NVH_CYC = (T_NVH_NS + CLK_NS - 1) / CLK_NS;
    localparam int NVHL_CYC = (T_NVHL_NS + CLK_NS - 1) / CLK_NS;
    localparam int PGS_CYC = (PROGRAM_SETUP_WAIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROG_CYC = (T_PROG_NS + CLK_NS - 1) / CLK_NS;
    localparam int RCV_CYC = (T_RCV_NS + CLK_NS - 1) / CLK_NS;
    // Host command codes
    typedef enum logic [1:0] {
        CMD_PROGRAM = 2'h0,
        CMD_PAGE_ERASE = 2'h1,
        CMD_MASS_ERASE = 2'h2
    } fpe_cmd_type;
endpackage
`default_nettype wire

//--- common/fpe_bus_if.sv
// Interface carrying the processor bus between host and flash sequencer.
`default_nettype none
interface fpe_bus_if;
    logic wrEn;
    logic rdEn;
    logic [15:0] addr;
    logic [7:0] wrData;
    logic [7:0] rdData;
    modport device (input wrEn, input rdEn, input addr, input wrData, output rdData);
    modport host (output wrEn, output rdEn, output addr, output wrData, input rdData);
endinterface
`default_nettype wire

//--- design/fpe_flash_ctrl.sv
// Flash sequencer: control and boundary registers, interlocks, array model.
`default_nettype none
module fpe_flash_ctrl #(
    parameter int USER_SIZE = 12288,
    parameter int VEC_SIZE = 48
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // Processor bus
    fpe_bus_if.device bus,
    // Analog control
    output logic pumpOn,
    output logic highVoltage,
    output logic eraseActive,
    output logic programActive
);
    import fpe_pkg::*;

    logic [3:0] ctrl;
    logic [7:0] protBits;
    logic addrLatched;
    logic [15:0] latchAddr;
    logic [7:0] userMem [USER_SIZE];
    logic [7:0] vecMem [VEC_SIZE];
    logic [7:0] next_ctrl;
    logic inUser;
    logic inVec;
    logic [15:0] protStart;
    logic latchProtected;
    logic ctrlWr;
    logic protWr;
    logic flashWr;
    logic [13:0] userIdx;
    logic [5:0] vecIdx;

    // Address decode over the two flash ranges
    assign inUser = (bus.addr >= USER_BASE) && (bus.addr <= USER_LAST);
    assign inVec = (bus.addr >= VEC_BASE);
    assign userIdx = 14'(bus.addr - USER_BASE);
    assign vecIdx = 6'(bus.addr - VEC_BASE);
    assign ctrlWr = bus.wrEn && (bus.addr == CTRL_ADDR);
    assign protWr = bus.wrEn && (bus.addr == PROT_ADDR);
    assign flashWr = bus.wrEn && (inUser || inVec);

    // Protect start: top two ones, boundary bits 7..1, seven zeros
    assign protStart = {2'b11, protBits[7:1], 7'h00};
    // Bit 0 matters only as part of the all-ones disable code
    assign latchProtected = (protBits != PROT_OFF) && (latchAddr >= protStart);

    // Next control value with interlocks applied
    always_comb begin
        next_ctrl = {4'h0, ctrl};
        if (ctrlWr) begin
            next_ctrl = {4'h0, bus.wrData[3:0]};
            // Both selects in one write, or one while the other holds: keep old selects
            if ((bus.wrData[BIT_WIPE] && bus.wrData[BIT_WRITE])
                    || (bus.wrData[BIT_WIPE] && ctrl[BIT_WRITE] && !ctrl[BIT_WIPE])
                    || (bus.wrData[BIT_WRITE] && ctrl[BIT_WIPE] && !ctrl[BIT_WRITE])) begin
                next_ctrl[BIT_WIPE] = ctrl[BIT_WIPE];
                next_ctrl[BIT_WRITE] = ctrl[BIT_WRITE];
            end
            // High voltage only after a select and its address write, outside protection
            if (bus.wrData[BIT_HV] && !ctrl[BIT_HV]) begin
                if (!(ctrl[BIT_WIPE] || ctrl[BIT_WRITE]) || !addrLatched
                        || latchProtected) begin
                    next_ctrl[BIT_HV] = 1'b0;
                end
            end
        end
    end

    // Control register; upper bits always read zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= CTRL_RESET[3:0];
        end else if (clkEn) begin
            ctrl <= next_ctrl[3:0];
        end
    end

    // Boundary register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            protBits <= PROT_RESET;
        end else if (clkEn && protWr) begin
            protBits <= bus.wrData;
        end
    end

    // First flash write after a select latches the target page or row
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addrLatched <= 1'b0;
            latchAddr <= 16'h0000;
        end else if (clkEn) begin
            if (!(ctrl[BIT_WIPE] || ctrl[BIT_WRITE])) begin
                addrLatched <= 1'b0;
            end else if (flashWr && !addrLatched) begin
                addrLatched <= 1'b1;
                latchAddr <= bus.addr;
            end
        end
    end

    // Array contents: erase sets bits, program only clears them
    always_ff @(posedge clk) begin
        if (clkEn && ctrl[BIT_HV]) begin
            if (ctrl[BIT_WIPE] && ctrl[BIT_MASS]) begin
                // Whole array, vector page included
                for (int i = 0; i < USER_SIZE; i++) begin
                    userMem[i] <= 8'hff;
                end
                for (int i = 0; i < VEC_SIZE; i++) begin
                    vecMem[i] <= 8'hff;
                end
            end else if (ctrl[BIT_WIPE]) begin
                // Single 128-byte page; the vector page is immune
                for (int i = 0; i < USER_SIZE; i++) begin
                    if (((USER_BASE + 16'(i)) >> PAGE_BITS) == (latchAddr >> PAGE_BITS)
                            && latchAddr <= USER_LAST) begin
                        userMem[i] <= 8'hff;
                    end
                end
            end else if (ctrl[BIT_WRITE] && flashWr
                    && ((bus.addr >> ROW_BITS) == (latchAddr >> ROW_BITS))) begin
                // Byte writes stay inside the latched 64-byte row
                if (inUser) begin
                    userMem[userIdx] <= userMem[userIdx] & bus.wrData;
                end else begin
                    vecMem[vecIdx] <= vecMem[vecIdx] & bus.wrData;
                end
            end
        end
        // Writes with no select fall through untouched; no timers here either
    end

    // Read data is registered
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus.rdData <= 8'h00;
        end else if (clkEn && bus.rdEn) begin
            if (bus.addr == CTRL_ADDR) begin
                bus.rdData <= {4'h0, ctrl};
            end else if (bus.addr == PROT_ADDR) begin
                bus.rdData <= protBits;
            end else if (inUser) begin
                bus.rdData <= userMem[userIdx];
            end else if (inVec) begin
                bus.rdData <= vecMem[vecIdx];
            end else begin
                bus.rdData <= 8'h00;
            end
        end
    end

    // Pump and array voltage follow the enable bit
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pumpOn <= 1'b0;
            highVoltage <= 1'b0;
            eraseActive <= 1'b0;
            programActive <= 1'b0;
        end else if (clkEn) begin
            pumpOn <= next_ctrl[BIT_HV];
            highVoltage <= next_ctrl[BIT_HV];
            eraseActive <= next_ctrl[BIT_HV] && next_ctrl[BIT_WIPE];
            programActive <= next_ctrl[BIT_HV] && next_ctrl[BIT_WRITE];
        end
    end
endmodule
`default_nettype wire

//--- design/fpe_flash_host.sv
// Host sequencer: walks the program and erase step orders with timed waits.
`default_nettype none
module fpe_flash_host #(
    parameter int NVS_WAIT = fpe_pkg::NVS_CYC,
    parameter int ERASE_WAIT = fpe_pkg::ERASE_CYC,
    parameter int MERASE_WAIT = fpe_pkg::MERASE_CYC,
    parameter int NVH_WAIT = fpe_pkg::NVH_CYC,
    parameter int NVHL_WAIT = fpe_pkg::NVHL_CYC,
    parameter int PGS_WAIT = fpe_pkg::PGS_CYC,
    parameter int PROG_WAIT = fpe_pkg::PROG_CYC,
    parameter int RCV_WAIT = fpe_pkg::RCV_CYC
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // User request
    input wire logic start,
    input wire fpe_pkg::fpe_cmd_type cmd,
    input wire logic [15:0] target,
    input wire logic [7:0] data,
    output logic busy,
    output logic done,
    // Processor bus
    fpe_bus_if.host bus
);
    import fpe_pkg::*;

    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_WR = 7'h02,
        S_WAIT = 7'h04,
        S_NEXT = 7'h08,
        S_HOLD = 7'h10,
        S_DONE = 7'h20,
        S_RCV = 7'h40
    } fpe_state_type;

    fpe_state_type state;
    logic [3:0] step;
    logic [21:0] timer;
    fpe_cmd_type curCmd;
    logic [15:0] curAddr;
    logic [7:0] curData;
    logic [5:0] byteCnt;

    // Step table: control writes, address writes, waits in strict order
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= S_IDLE;
            step <= 4'h0;
            timer <= 22'h000000;
            curCmd <= CMD_PROGRAM;
            curAddr <= 16'h0000;
            curData <= 8'h00;
            byteCnt <= 6'h00;
            busy <= 1'b0;
            done <= 1'b0;
            bus.wrEn <= 1'b0;
            bus.rdEn <= 1'b0;
            bus.addr <= 16'h0000;
            bus.wrData <= 8'h00;
        end else if (clkEn) begin
            done <= 1'b0;
            bus.wrEn <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (start) begin
                        curCmd <= cmd;
                        curAddr <= target;
                        curData <= data;
                        byteCnt <= 6'h00;
                        step <= 4'h0;
                        busy <= 1'b1;
                        state <= S_WR;
                    end
                end
                S_WR: begin
                    // One bus write per pass, then its wait; step 3 writes once per row byte, and not at all for erase
                    bus.wrEn <= 1'b1;
                    state <= S_WAIT;
                    case (step)
                        4'h0: begin
                            bus.addr <= CTRL_ADDR;
                            bus.wrData <= (curCmd == CMD_PROGRAM) ? 8'h01
                                : (curCmd == CMD_MASS_ERASE) ? 8'h06 : 8'h02;
                            timer <= 22'h000001;
                        end
                        4'h1: begin
                            bus.addr <= curAddr;
                            bus.wrData <= curData;
                            timer <= 22'(NVS_WAIT);
                        end
                        4'h2: begin
                            bus.addr <= CTRL_ADDR;
                            bus.wrData <= (curCmd == CMD_PROGRAM) ? 8'h09
                                : (curCmd == CMD_MASS_ERASE) ? 8'h0e : 8'h0a;
                            timer <= (curCmd == CMD_PROGRAM) ? 22'(PGS_WAIT)
                                : (curCmd == CMD_MASS_ERASE) ? 22'(MERASE_WAIT)
                                : 22'(ERASE_WAIT);
                        end
                        4'h3: begin
                            // Row byte writes; erase skips straight to select clear
                            bus.wrEn <= (curCmd == CMD_PROGRAM);
                            bus.addr <= {curAddr[15:6], byteCnt};
                            bus.wrData <= curData;
                            timer <= (curCmd == CMD_PROGRAM) ? 22'(PROG_WAIT) : 22'h000001;
                        end
                        4'h4: begin
                            bus.addr <= CTRL_ADDR;
                            bus.wrData <= 8'h08;
                            timer <= (curCmd == CMD_MASS_ERASE) ? 22'(NVHL_WAIT)
                                : 22'(NVH_WAIT);
                        end
                        default: begin
                            bus.addr <= CTRL_ADDR;
                            bus.wrData <= 8'h00;
                            timer <= 22'(RCV_WAIT);
                        end
                    endcase
                end
                S_WAIT: begin
                    if (timer <= 22'h000001) begin
                        state <= S_NEXT;
                    end else begin
                        timer <= timer - 22'h000001;
                    end
                end
                S_NEXT: begin
                    if (step == 4'h3 && curCmd == CMD_PROGRAM && byteCnt != 6'h3f) begin
                        byteCnt <= byteCnt + 6'h01;
                        state <= S_WR;
                    end else if (step == 4'h5) begin
                        state <= S_DONE;
                    end else begin
                        step <= step + 4'h1;
                        state <= S_WR;
                    end
                end
                S_DONE: begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
    // Fetches come from elsewhere; this sequencer never reads the array.
endmodule
`default_nettype wire

//--- tb/fpe_bus_properties.sv
// Checker watching the bus and analog outputs between host and flash sequencer.
`default_nettype none
module fpe_bus_properties
    import fpe_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // Bus
    input wire logic wrEn,
    input wire logic [15:0] addr,
    input wire logic [7:0] wrData,
    // Analog control
    input wire logic pumpOn,
    input wire logic highVoltage,
    input wire logic eraseActive,
    input wire logic programActive
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    logic ctrlWrite;
    logic hvWrite;
    logic isFlash;
    logic [7:0] shadowProt;
    logic [15:0] lastFlash;
    logic [15:0] protStart;

    // Decoded bus events
    assign ctrlWrite = wrEn && clkEn && addr == CTRL_ADDR;
    assign hvWrite = ctrlWrite && wrData[BIT_HV];
    assign isFlash = (addr >= USER_BASE && addr <= USER_LAST) || addr >= VEC_BASE;
    assign protStart = {2'b11, shadowProt[7:1], 7'h00};

    // Boundary copy, so protection follows what the bus last wrote
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shadowProt <= PROT_RESET;
        end else if (wrEn && clkEn && addr == PROT_ADDR) begin
            shadowProt <= wrData;
        end
    end

    // Last flash address; reset to the top so a missing latch cannot pass
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lastFlash <= 16'hffff;
        end else if (wrEn && clkEn && isFlash) begin
            lastFlash <= addr;
        end
    end

    a_pump_follows_hv: assert property (pumpOn == highVoltage)
        else $error("pump and high voltage disagree");
    a_active_needs_hv: assert property ((eraseActive || programActive) |-> highVoltage)
        else $error("erase or program active without high voltage");
    a_selects_exclusive: assert property (!(eraseActive && programActive))
        else $error("erase and program active together");
    a_hv_set_cause: assert property ($rose(highVoltage) |-> $past(hvWrite))
        else $error("high voltage rose without a control write");
    a_hv_clear_write: assert property (ctrlWrite && !wrData[BIT_HV] |=> !highVoltage)
        else $error("high voltage stayed on after clearing write");
    a_hv_outside_protect: assert property ($rose(highVoltage) |->
        (shadowProt == PROT_OFF || lastFlash < protStart))
        else $error("high voltage rose inside protected range");
    a_ctrl_upper_zero: assert property (ctrlWrite |-> wrData[7:4] == 4'h0)
        else $error("control write with upper bits set");
    a_one_select_only: assert property (ctrlWrite |->
        !(wrData[BIT_WIPE] && wrData[BIT_WRITE]))
        else $error("control write sets both selects");

    // Main host sequences seen on the bus
    c_program: cover property (ctrlWrite && wrData == 8'h01);
    c_page_erase: cover property (ctrlWrite && wrData == 8'h02);
    c_mass_erase: cover property (ctrlWrite && wrData == 8'h06);
endmodule
`default_nettype wire

//--- tb/flash_program_erase_protect_tb.sv
// Testbench: host against sequencer, plus a bench-driven second sequencer.
`default_nettype none
module flash_program_erase_protect_tb;
    import fpe_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [7:0] bound;
        logic [15:0] where;
        logic hv;
    } fpe_prot_row_type;

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clkEn = 1'b1;
    logic start = 1'b0;
    fpe_cmd_type cmd = CMD_PROGRAM;
    logic [15:0] target = 16'hc040;
    logic [7:0] data = 8'h5a;
    logic busy, done, hvSeenA;
    logic pumpA, hvA, eraseA, progA, pumpB, hvB, eraseB, progB;
    int fail_count = 0;
    int n_checks = 0;
    // Boundary, erase address, expected high voltage
    fpe_prot_row_type rows [0:7] = '{'{8'h00, 16'hc000, 1'b0}, '{8'h02, 16'hc07f, 1'b1},
        '{8'h02, 16'hc080, 1'b0}, '{8'h03, 16'hc07f, 1'b1}, '{8'hfe, 16'hefff, 1'b1},
        '{8'hfe, 16'hffd0, 1'b0}, '{8'hff, 16'hffff, 1'b1}, '{8'hfc, 16'hffff, 1'b0}};

    fpe_bus_if busA();
    fpe_bus_if busB();

    always #20 clk = ~clk;

    // Host and sequencer facing each other; short waits keep the run brief
    fpe_flash_host #(.NVS_WAIT(3), .ERASE_WAIT(3), .MERASE_WAIT(3), .NVH_WAIT(3),
        .NVHL_WAIT(3), .PGS_WAIT(3), .PROG_WAIT(3), .RCV_WAIT(3)) fpe_flash_host_i (
        .clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .start(start), .cmd(cmd),
        .target(target), .data(data), .busy(busy), .done(done), .bus(busA));
    fpe_flash_ctrl fpe_flash_ctrl_i (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
        .bus(busA), .pumpOn(pumpA), .highVoltage(hvA), .eraseActive(eraseA),
        .programActive(progA));
    // Second sequencer, driven by the bench so it can misbehave on purpose
    fpe_flash_ctrl fpe_flash_ctrl_i2 (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
        .bus(busB), .pumpOn(pumpB), .highVoltage(hvB), .eraseActive(eraseB),
        .programActive(progB));
    fpe_bus_properties fpe_bus_properties_i (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
        .wrEn(busA.wrEn), .addr(busA.addr), .wrData(busA.wrData), .pumpOn(pumpA),
        .highVoltage(hvA), .eraseActive(eraseA), .programActive(progA));

    // Remember any high voltage on the host pair
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hvSeenA <= 1'b0;
        end else if (hvA) begin
            hvSeenA <= 1'b1;
        end
    end

    task automatic tick();
        @(posedge clk);
        #5;
    endtask

    task automatic stop_test();
        $display("Checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk1(input string name, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Strobe drops for one edge so it never rises twice in one step
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        busB.addr = a;
        busB.wrData = d;
        busB.wrEn = 1'b1;
        tick();
        busB.wrEn = 1'b0;
        tick();
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        busB.addr = a;
        busB.rdEn = 1'b1;
        tick();
        busB.rdEn = 1'b0;
        chk8($sformatf("read %h", a), exp, busB.rdData);
        tick();
    endtask

    // First write carries ff, which cannot clear any bit
    task automatic prog(input logic [15:0] a, input logic [7:0] d);
        wr(CTRL_ADDR, 8'h01);
        wr(a, 8'hff);
        wr(CTRL_ADDR, 8'h09);
        chk1("program active", 1'b1, progB);
        wr(a, d);
        wr(16'hc085, 8'h00);
        wr(CTRL_ADDR, 8'h08);
        wr(CTRL_ADDR, 8'h00);
    endtask

    task automatic erase(input logic [7:0] m, input logic [15:0] a);
        wr(CTRL_ADDR, m);
        wr(a, 8'h00);
        wr(CTRL_ADDR, m | 8'h08);
        chk1("erase active", 1'b1, eraseB);
        wr(CTRL_ADDR, 8'h08);
        wr(CTRL_ADDR, 8'h00);
    endtask

    // One full host sequence; the done pulse stands one cycle, so poll every edge
    task automatic host_run(input fpe_cmd_type c, input logic [15:0] t, input logic [7:0] d);
        cmd = c;
        target = t;
        data = d;
        start = 1'b1;
        tick();
        start = 1'b0;
        chk1("host busy", 1'b1, busy);
        for (int n = 0; n < 3000 && done !== 1'b1; n++) begin
            tick();
        end
        chk1("host done", 1'b1, done);
        tick();
    endtask

    initial begin
        #(40 * 40000);
        fail_count++;
        stop_test();
    end

    initial begin
        busB.wrEn = 1'b0;
        busB.rdEn = 1'b0;
        busB.addr = 16'h0000;
        busB.wrData = 8'h00;
        repeat (6) @(posedge clk);
        #5;
        sys_rst = 1'b0;
        tick();
        foreach (rows[i]) begin
            wr(PROT_ADDR, rows[i].bound);
            wr(CTRL_ADDR, 8'h02);
            wr(rows[i].where, 8'h00);
            wr(CTRL_ADDR, 8'h0a);
            chk1("protect hv", rows[i].hv, hvB);
            chk1("pump", rows[i].hv, pumpB);
            wr(CTRL_ADDR, 8'h08);
            wr(CTRL_ADDR, 8'h00);
            chk1("hv off", 1'b0, hvB);
        end
        // Second reset in mid-run
        sys_rst = 1'b1;
        tick();
        sys_rst = 1'b0;
        tick();
        rd(CTRL_ADDR, CTRL_RESET);
        rd(PROT_ADDR, PROT_RESET);
        // Reset boundary guards the whole array, so the host never gets high voltage
        for (int c = 0; c < 3; c++) begin
            host_run(fpe_cmd_type'(c), 16'hc040, 8'h5a);
        end
        chk1("reset boundary blocks hv", 1'b0, hvSeenA);
        // Host opens the boundary as unrelated traffic; nothing latched, so no high voltage
        host_run(CMD_PAGE_ERASE, PROT_ADDR, PROT_OFF);
        chk1("no latch blocks hv", 1'b0, hvSeenA);
        for (int c = 0; c < 3; c++) begin
            host_run(fpe_cmd_type'(c), 16'hc0c0, 8'ha5);
        end
        chk1("open boundary allows hv", 1'b1, hvSeenA);
        wr(CTRL_ADDR, 8'h08);
        rd(CTRL_ADDR, 8'h00);
        wr(PROT_ADDR, PROT_OFF);
        wr(16'hfe0a, 8'h00);
        rd(PROT_ADDR, PROT_OFF);
        wr(CTRL_ADDR, 8'h02);
        wr(CTRL_ADDR, 8'h0a);
        rd(CTRL_ADDR, 8'h02);
        // Both selects at once keep the old ones: wipe stays, mass lands, no high voltage
        wr(CTRL_ADDR, 8'hff);
        rd(CTRL_ADDR, 8'h06);
        wr(CTRL_ADDR, 8'h00);
        wr(CTRL_ADDR, 8'h01);
        wr(CTRL_ADDR, 8'h03);
        rd(CTRL_ADDR, 8'h01);
        wr(CTRL_ADDR, 8'h00);
        erase(8'h06, 16'hc000);
        rd(16'hc000, 8'hff);
        rd(16'hffd0, 8'hff);
        wr(16'hc100, 8'h00);
        rd(16'hc100, 8'hff);
        prog(16'hc045, 8'ha5);
        rd(16'hc045, 8'ha5);
        rd(16'hc085, 8'hff);
        prog(16'hc045, 8'h5a);
        rd(16'hc045, 8'h00);
        prog(16'hc080, 8'h11);
        prog(16'hffd0, 8'h3c);
        erase(8'h02, 16'hc010);
        rd(16'hc045, 8'hff);
        rd(16'hc080, 8'h11);
        erase(8'h02, 16'hffd0);
        rd(16'hffd0, 8'h3c);
        // Enable low freezes the register: the write must not land
        clkEn = 1'b0;
        wr(CTRL_ADDR, 8'h01);
        clkEn = 1'b1;
        rd(CTRL_ADDR, 8'h00);
        stop_test();
    end
endmodule
`default_nettype wire
